// ---- logic/fsp_ctrl.sv ----
// module: flash self-program sequencer with apb control register
//
// Register access over APB and the register addresses were chosen for this implementation.
module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter logic [TIMER_W-1:0] PROG_CYCLES_P = TIMER_W'(PROG_CYCLES)
) (
  input wire logic clk_i,
  input wire logic rst_i, // system reset, spares a running write
  input wire logic por_i, // power-on reset, clears everything
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic spm_i, // cpu executes a store program memory
  input wire logic lpm_i, // cpu executes a byte load program memory
  input wire logic [15:0] z_i, // address pointer
  input wire logic [7:0] r0_i,
  input wire logic [7:0] r1_i,
  input wire logic eeprom_write_busy_i,
  input wire logic [1:0] main_lock_i,
  input wire logic [7:0] fuse_low_i,
  input wire logic [7:0] fuse_high_i,
  input wire logic [3:0] fuse_ext_i,
  output logic cpu_halt_o,
  output logic lower_read_block_o,
  output logic lpm_valid_o,
  output logic lpm_special_o,
  output logic [7:0] lpm_data_o,
  output logic irq_o,
  output logic buf_write_o,
  output logic [5:0] buf_word_o,
  output logic [15:0] buf_data_o,
  output logic buf_clear_o,
  output logic flash_erase_o,
  output logic flash_write_o,
  output logic [6:0] flash_page_o,
  output logic lock_prog_o,
  output logic [3:0] boot_lock_o
);

  // ************************************************************
  // state
  // ************************************************************
  logic sys_rst; // resets the arming side
  fsp_cmd_t cmd_q, cmd_d; // armed command
  fsp_op_t op_q, op_d; // running flash operation
  logic armed_q, armed_d; // a store or load is armed
  logic int_en_q, int_en_d; // completion interrupt enable
  logic busy_flag_q, busy_flag_d; // section_busy_flag
  logic upper_q, upper_d; // running op targets the upper section
  logic [6:0] page_q, page_d; // latched page address
  logic [3:0] boot_lock_q, boot_lock_d; // boot lock bits
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] rd_byte; // selected lock or fuse byte

  assign sys_rst = rst_i | por_i;

  // ************************************************************
  // apb decode
  // ************************************************************
  wire apb_setup = psel_i & ~penable_i;
  wire apb_commit = psel_i & penable_i & pready_q;
  wire hit_ctrl = (paddr_i == CTRL_OFS);
  wire hit_lock = (paddr_i == LOCK_OFS);
  wire hit_any = hit_ctrl | hit_lock;
  // the lock view is read only, so a write there is an error
  wire bad_acc = ~hit_any | (pwrite_i & hit_lock);
  wire ctrl_wr = apb_commit & pwrite_i & hit_ctrl & pstrb_i[0];
  wire [4:0] pat = pwdata_i[4:0];
  wire busy_now = (op_q != OP_IDLE);
  wire store_enable = armed_q | busy_now; // store_enable_bit view

  // ************************************************************
  // command decode
  // ************************************************************
  wire pat_legal = (pat == PAT_FILL) | (pat == PAT_ERASE) | (pat == PAT_WRITE) |
                   (pat == PAT_LOCK) | (pat == PAT_REEN);
  // arming refused during eeprom writes and while an op runs
  wire arm_req = ctrl_wr & pat_legal & ~eeprom_write_busy_i & ~store_enable;
  fsp_cmd_t cmd_wr;
  assign cmd_wr = (pat == PAT_ERASE) ? CMD_ERASE :
                  (pat == PAT_WRITE) ? CMD_WRITE :
                  (pat == PAT_LOCK) ? CMD_LOCK :
                  (pat == PAT_REEN) ? CMD_REEN : CMD_FILL;

  // ************************************************************
  // arming windows
  // ************************************************************
  logic store_live, store_last, load_live, timer_last;
  wire spm_take = spm_i & armed_q & store_live & ~eeprom_write_busy_i;
  wire lpm_take = lpm_i & armed_q & (cmd_q == CMD_LOCK) & load_live &
                  ~eeprom_write_busy_i;
  wire is_page = (cmd_q == CMD_ERASE) | (cmd_q == CMD_WRITE);
  wire start_page = spm_take & is_page;
  wire start_lock = spm_take & (cmd_q == CMD_LOCK);
  wire reen_take = spm_take & (cmd_q == CMD_REEN);
  wire prog_done = busy_now & timer_last;
  wire upper_z = (z_i[13:11] == UPPER_Z_MSBS);
  wire [6:0] z_page = z_i[13:7];
  wire [3:0] r0_lock = r0_i[5:2];

  // store window reloads on every accepted arming
  fsp_countdown #(.W(WIN_W)) u_store_win (
    .clk_i(clk_i),
    .rst_i(sys_rst),
    .load_i(arm_req),
    .load_val_i(STORE_WIN),
    .clear_i(spm_take | lpm_take),
    .live_o(store_live),
    .last_o(store_last)
  );

  // load window for lock and fuse reads
  fsp_countdown #(.W(WIN_W)) u_load_win (
    .clk_i(clk_i),
    .rst_i(sys_rst),
    .load_i(arm_req),
    .load_val_i(LOAD_WIN),
    .clear_i(spm_take | lpm_take),
    .live_o(load_live),
    .last_o()
  );

  // write timer survives system reset; clk counts stand in for the rc clock
  fsp_countdown #(.W(TIMER_W)) u_prog_timer (
    .clk_i(clk_i),
    .rst_i(por_i),
    .load_i(start_page | start_lock),
    .load_val_i(PROG_CYCLES_P),
    .clear_i(1'b0),
    .live_o(),
    .last_o(timer_last)
  );

  fsp_lock_read u_lock_read (
    .z_i(z_i),
    .boot_lock_i(boot_lock_q),
    .main_lock_i(main_lock_i),
    .fuse_low_i(fuse_low_i),
    .fuse_high_i(fuse_high_i),
    .fuse_ext_i(fuse_ext_i),
    .data_o(rd_byte)
  );

  // ************************************************************
  // next-state logic
  // ************************************************************
  // arming clears on use, on store-window timeout, or re-arms
  assign armed_d = arm_req ? 1'b1 : (spm_take | lpm_take | store_last) ? 1'b0 : armed_q;
  assign cmd_d = arm_req ? cmd_wr : armed_d ? cmd_q : CMD_NONE;
  assign int_en_d = ctrl_wr ? pwdata_i[BIT_INT_EN] : int_en_q;
  // op ends on timer expiry; the pointer plays no part in lock op
  assign op_d = prog_done ? OP_IDLE :
                (start_page & (cmd_q == CMD_ERASE)) ? OP_ERASE :
                start_page ? OP_WRITE :
                start_lock ? OP_LOCK : op_q;
  assign upper_d = start_page ? upper_z : upper_q;
  assign page_d = start_page ? z_page : page_q;
  // only zeros program, ones leave the bit as it was
  assign boot_lock_d = start_lock ? (boot_lock_q & r0_lock) : boot_lock_q;
  // set wins over clear; re-enable ignored while an op runs
  assign busy_flag_d = start_page ? 1'b1 : (reen_take & ~busy_now) ? 1'b0 : busy_flag_q;
  wire page_op_d = (op_d == OP_ERASE) | (op_d == OP_WRITE);
  wire store_enable_d = armed_d | (op_d != OP_IDLE);

  // ************************************************************
  // arming side registers, cleared by either reset
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
      cmd_q <= CMD_NONE;
      int_en_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
      cmd_q <= cmd_d;
      int_en_q <= int_en_d;
    end
  end

  // ************************************************************
  // operation registers, only power-on reset clears them
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      op_q <= OP_IDLE;
      upper_q <= 1'b0;
      page_q <= 7'h00;
      busy_flag_q <= 1'b0;
      boot_lock_q <= BOOT_LOCK_RST;
    end else begin
      op_q <= op_d;
      upper_q <= upper_d;
      page_q <= page_d;
      busy_flag_q <= busy_flag_d;
      boot_lock_q <= boot_lock_d;
    end
  end

  // ************************************************************
  // flash macro and cpu stall outputs
  // ************************************************************
  // halt only for upper targets; lower targets keep fetching
  // lower reads blocked for page ops only, never for lock op
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      cpu_halt_o <= 1'b0;
      lower_read_block_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      lock_prog_o <= 1'b0;
      flash_page_o <= 7'h00;
      boot_lock_o <= BOOT_LOCK_RST;
    end else begin
      cpu_halt_o <= page_op_d & upper_d;
      lower_read_block_o <= page_op_d;
      flash_erase_o <= (op_d == OP_ERASE);
      flash_write_o <= (op_d == OP_WRITE);
      lock_prog_o <= (op_d == OP_LOCK);
      flash_page_o <= page_d;
      boot_lock_o <= boot_lock_d;
    end
  end

  // ************************************************************
  // cpu-facing pulses, interrupt and special loads
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      irq_o <= 1'b0;
      lpm_valid_o <= 1'b0;
      lpm_special_o <= 1'b0;
      lpm_data_o <= 8'h00;
      buf_write_o <= 1'b0;
      buf_word_o <= 6'h00;
      buf_data_o <= 16'h0000;
      buf_clear_o <= 1'b0;
    end else begin
      irq_o <= int_en_d & ~store_enable_d;
      lpm_valid_o <= lpm_i;
      lpm_special_o <= lpm_take;
      lpm_data_o <= lpm_take ? rd_byte : 8'h00;
      buf_write_o <= spm_take & (cmd_q == CMD_FILL);
      buf_word_o <= z_i[6:1];
      buf_data_o <= {r1_i, r0_i};
      buf_clear_o <= reen_take & ~busy_now;
    end
  end

  // ************************************************************
  // apb slave: no wait states, answer registered in setup
  // ************************************************************
  wire [7:0] ctrl_view = {int_en_q, busy_flag_q, 1'b0, 1'b0,
                          armed_q & (cmd_q == CMD_LOCK),
                          (armed_q & (cmd_q == CMD_WRITE)) | (op_q == OP_WRITE),
                          (armed_q & (cmd_q == CMD_ERASE)) | (op_q == OP_ERASE),
                          store_enable};
  wire [7:0] lock_view = {LOCK_TOP, boot_lock_q, main_lock_i};
  wire [31:0] rd_word = hit_ctrl ? {24'h000000, ctrl_view} :
                        hit_lock ? {24'h000000, lock_view} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & bad_acc;
      prdata_q <= (apb_setup & ~pwrite_i) ? rd_word : 32'h00000000;
    end
  end

  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign prdata_o = prdata_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst);

  sequence s_armed_idle;
    arm_req ##1 (!spm_i && !lpm_i) [*4];
  endsequence

  a_lower_no_halt: assert property ((op_q == OP_WRITE) && !upper_q |-> !cpu_halt_o)
    else $error("cpu halted during lower-section write");
  a_upper_halt: assert property (start_page && upper_z |=> cpu_halt_o [*8])
    else $error("cpu not halted during upper-section op");
  a_irq_level: assert property (int_en_q && !store_enable |-> irq_o)
    else $error("interrupt missing while store enable low");
  a_lower_block: assert property (start_page |=> lower_read_block_o [*8])
    else $error("lower-section reads not blocked during page op");
  a_busy_hold: assert property (busy_flag_q && !reen_take |=> busy_flag_q)
    else $error("busy flag dropped without re-enable");
  a_busy_clear: assert property ($fell(busy_flag_q) |-> $past(reen_take))
    else $error("busy flag cleared by something other than re-enable");
  a_lock_prog: assert property (start_lock |=>
                                boot_lock_o == ($past(boot_lock_q) & $past(r0_lock)))
    else $error("boot lock bits not programmed from data");
  a_lock_noblock: assert property ((op_q == OP_LOCK) |->
                                   !lower_read_block_o && !cpu_halt_o)
    else $error("flash blocked during lock programming");
  a_ee_blocks: assert property (eeprom_write_busy_i |=> !lpm_special_o && !buf_write_o)
    else $error("programming access during eeprom write");
  a_lock_read: assert property (lpm_take && (z_i == Z_LOCK) |=>
                                lpm_data_o == {LOCK_TOP, $past(boot_lock_q), $past(main_lock_i)})
    else $error("wrong lock byte returned");
  a_arm_timeout: assert property (s_armed_idle |=> !armed_q)
    else $error("arming not cleared after window");
  a_fuse_low: assert property (lpm_take && (z_i == Z_FUSE_LOW) |=>
                               lpm_data_o == $past(fuse_low_i))
    else $error("wrong low fuse byte returned");
  a_fuse_high: assert property (lpm_take && (z_i == Z_FUSE_HIGH) |=>
                                lpm_data_o == $past(fuse_high_i))
    else $error("wrong high fuse byte returned");
  a_fuse_ext: assert property (lpm_take && (z_i == Z_FUSE_EXT) |=>
                               lpm_data_o == {EXT_PAD, $past(fuse_ext_i)})
    else $error("wrong extended fuse byte returned");
  a_plain_load: assert property (lpm_i && !armed_q |=> lpm_valid_o && !lpm_special_o)
    else $error("unarmed load treated as special");
  a_store_held: assert property (busy_now |-> store_enable && irq_o == 1'b0)
    else $error("store enable low during running op");
  a_page_latch: assert property (start_page |=> flash_page_o == $past(z_page))
    else $error("page address not latched from pointer");

endmodule // fsp_ctrl

// ---- logic/fsp_pkg.sv ----
// package: constants and types for the flash self-program control block
package fsp_pkg;

  // ************************************************************
  // register map (byte addresses on the apb bus)
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000; // self_prog_control_reg
  localparam logic [11:0] LOCK_OFS = 12'h004; // read-only view of the lock byte

  // ************************************************************
  // control register field positions
  // ************************************************************
  localparam int BIT_STORE_EN = 0; // store_enable_bit
  localparam int BIT_PAGE_ERASE = 1; // page erase command
  localparam int BIT_PAGE_WRITE = 2; // page_write_bit
  localparam int BIT_LOCK_ACCESS = 3; // lock_access_bit
  localparam int BIT_REENABLE = 4; // section_reenable_bit
  localparam int BIT_BUSY = 6; // section_busy_flag, read only
  localparam int BIT_INT_EN = 7; // completion interrupt enable

  // ************************************************************
  // legal command patterns in the low five control bits
  // ************************************************************
  localparam logic [4:0] PAT_FILL = 5'h01;
  localparam logic [4:0] PAT_ERASE = 5'h03;
  localparam logic [4:0] PAT_WRITE = 5'h05;
  localparam logic [4:0] PAT_LOCK = 5'h09;
  localparam logic [4:0] PAT_REEN = 5'h11;

  // ************************************************************
  // arming windows and programming time
  // ************************************************************
  localparam int WIN_W = 3;
  localparam logic [2:0] STORE_WIN = 3'h4; // cycles a store may follow arming
  localparam logic [2:0] LOAD_WIN = 3'h3; // cycles a byte load may follow arming
  localparam int TIMER_W = 19;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_MIN_NS = 3700000; // 3.7 ms least write time
  localparam int PROG_TIME_MAX_NS = 4500000; // 4.5 ms longest write time
  localparam int PROG_CYCLES = (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // pointer decoding and lock/fuse layout
  // ************************************************************
  localparam logic [2:0] UPPER_Z_MSBS = 3'h7; // z[13:11] all set: upper 16 pages
  localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
  localparam logic [15:0] Z_LOCK = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  localparam logic [3:0] BOOT_LOCK_RST = 4'hf; // all unprogrammed
  localparam logic [1:0] LOCK_TOP = 2'h3; // unused lock bits read one
  localparam logic [3:0] EXT_PAD = 4'hf; // unused extended fuse bits read one
  localparam logic [7:0] NO_FUSE = 8'hff; // other pointer values

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    CMD_NONE, CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_REEN
  } fsp_cmd_t;
  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE, OP_LOCK} fsp_op_t;

endpackage : fsp_pkg

// ---- logic/fsp_countdown.sv ----
// module: small loadable down counter used for arming windows and write timing
module fsp_countdown #(
  parameter int W = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic clear_i,
  output logic live_o,
  output logic last_o
);

  logic [W-1:0] cnt_q; // remaining cycles
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  // load wins over clear so a fresh arming is never lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= load_val_i;
    end else if (clear_i) begin
      cnt_q <= '0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - ONE;
    end
  end

  assign live_o = (cnt_q != '0); // window still open
  assign last_o = (cnt_q == ONE); // final cycle of the window

endmodule // fsp_countdown

// ---- logic/fsp_lock_read.sv ----
// module: selects the lock or fuse byte returned by a special byte load
module fsp_lock_read
  import fsp_pkg::*;
(
  input wire logic [15:0] z_i,
  input wire logic [3:0] boot_lock_i,
  input wire logic [1:0] main_lock_i,
  input wire logic [7:0] fuse_low_i,
  input wire logic [7:0] fuse_high_i,
  input wire logic [3:0] fuse_ext_i,
  output logic [7:0] data_o
);

  // bits are stored raw: zero means programmed, one unprogrammed
  wire [7:0] lock_byte = {LOCK_TOP, boot_lock_i, main_lock_i};
  wire [7:0] ext_byte = {EXT_PAD, fuse_ext_i};
  wire sel_low = (z_i == Z_FUSE_LOW);
  wire sel_lock = (z_i == Z_LOCK);
  wire sel_ext = (z_i == Z_FUSE_EXT);
  wire sel_high = (z_i == Z_FUSE_HIGH);

  // pointer values outside the four read as all unprogrammed
  assign data_o = sel_low ? fuse_low_i :
                  sel_lock ? lock_byte :
                  sel_ext ? ext_byte :
                  sel_high ? fuse_high_i : NO_FUSE;

endmodule // fsp_lock_read

// ---- testbench/fsp_cpu_model.sv ----
// cpu core model: store and byte-load program memory pulses
module fsp_cpu_model (
  input wire logic clk_i,
  output logic spm_o,
  output logic lpm_o,
  output logic [15:0] z_o,
  output logic [7:0] r0_o,
  output logic [7:0] r1_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // instruction pulses, one cycle each
  // ************************************************************
  initial begin
    spm_o = 1'b0;
    lpm_o = 1'b0;
    z_o = 16'h0000;
    r0_o = 8'hff;
    r1_o = 8'h00;
  end
  // store: lock data sits in r0, r1 gets a changing pattern
  task automatic store(input logic [15:0] z, input logic [7:0] d);
    z_o <= z;
    r0_o <= d;
    r1_o <= ~r1_o;
    spm_o <= 1'b1;
    @(posedge clk_i);
    spm_o <= 1'b0;
  endtask
  // byte load from pointer z
  task automatic load(input logic [15:0] z);
    z_o <= z;
    lpm_o <= 1'b1;
    @(posedge clk_i);
    lpm_o <= 1'b0;
  endtask
endmodule // fsp_cpu_model

// ---- testbench/tb.sv ----
// testbench: apb master and cpu model drive the self-program sequencer
module tb;
  import fsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // signals and design
  // ************************************************************
  localparam int PROG = 20; // short write time keeps the run brief
  logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, eeprom_write_busy_i = 1'b0, pready_o, pslverr_o, spm_i, lpm_i;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic [3:0] pstrb_i = 4'hf, fuse_ext_i, boot_lock_o;
  logic [15:0] z_i, zp;
  logic [6:0] flash_page_o;
  logic [7:0] r0_i, r1_i, fuse_low_i, fuse_high_i, lpm_data_o, r;
  logic [1:0] main_lock_i;
  logic cpu_halt_o, lower_read_block_o, lpm_valid_o, lpm_special_o, irq_o, flash_write_o;
  logic lock_prog_o, err;
  int n_errors = 0, cmp_count = 0, seed = 32'h3e70e621, bl = 15, k, n;
  always #5 clk_i = ~clk_i;
  fsp_ctrl #(.PROG_CYCLES_P(TIMER_W'(PROG))) fsp_ctrl_inst (.clk_i, .rst_i, .por_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
    .spm_i, .lpm_i, .z_i, .r0_i, .r1_i, .eeprom_write_busy_i, .main_lock_i, .fuse_low_i,
    .fuse_high_i, .fuse_ext_i, .cpu_halt_o, .lower_read_block_o, .lpm_valid_o, .lpm_special_o,
    .lpm_data_o, .irq_o, .buf_write_o(), .buf_word_o(), .buf_data_o(), .buf_clear_o(),
    .flash_erase_o(), .flash_write_o, .flash_page_o, .lock_prog_o, .boot_lock_o);
  fsp_cpu_model fsp_cpu_model_inst (.clk_i, .spm_o(spm_i), .lpm_o(lpm_i), .z_o(z_i),
    .r0_o(r0_i), .r1_o(r1_i));
  // ************************************************************
  // compare, report, bus and wait tasks
  // ************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one apb transfer; an edge first so psel never toggles twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      final_report();
    end
  endtask
  // count cycles while a page write or lock operation runs, bounded
  task automatic wait_op();
    n = 0;
    while ((flash_write_o | lock_prog_o) !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 1000) begin
      n_errors++;
      final_report();
    end
  endtask
  // expected lock or fuse byte; raw bits already read zero when programmed
  function automatic logic [7:0] fuse_exp(input int zz);
    case (zz)
      0: return fuse_low_i;
      1: return {2'b11, 4'(bl), main_lock_i};
      2: return {4'hf, fuse_ext_i};
      3: return fuse_high_i;
      default: return 8'hff;
    endcase
  endfunction
  // arm a lock read, wait gap cycles, then load
  task automatic rd_special(input int zz, input logic ok, input int gap);
    apb(1'b1, CTRL_OFS, 32'h09);
    repeat (gap) @(posedge clk_i);
    fsp_cpu_model_inst.load(16'(zz));
    #1;
    check(32'(lpm_special_o), 32'(ok));
    check(32'(lpm_data_o), ok ? 32'(fuse_exp(zz)) : 32'h0);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    main_lock_i = 2'($random(seed));
    fuse_low_i = 8'($random(seed));
    fuse_high_i = 8'($random(seed));
    fuse_ext_i = 4'($random(seed));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    apb(1'b0, LOCK_OFS, 32'h0);
    check(rd, {24'h0, 2'b11, 4'hf, main_lock_i});
    apb(1'b0, 12'h0f0, 32'h0);
    check(32'(err), 32'h1);
    for (int i = 0; i < 5; i++) rd_special(i, 1'b1, i % 3);
    rd_special(1, 1'b0, 3);
    rd_special(1, 1'b0, 4);
    fsp_cpu_model_inst.load(16'h0001);
    #1;
    check(32'(lpm_special_o), 32'h0);
    check(32'(lpm_valid_o), 32'h1);
    eeprom_write_busy_i <= 1'b1;
    rd_special(1, 1'b0, 0);
    eeprom_write_busy_i <= 1'b0;
    // lock programming with a random pointer
    r = 8'($random(seed));
    bl = bl & r[5:2];
    apb(1'b1, CTRL_OFS, 32'h09);
    fsp_cpu_model_inst.store(16'($random(seed)), r);
    #1;
    check(32'(boot_lock_o), 32'(bl));
    check(32'(lower_read_block_o), 32'h0);
    wait_op();
    check(n, PROG);
    rd_special(1, 1'b1, 0);
    // page write to the upper section with interrupt enabled
    apb(1'b1, CTRL_OFS, 32'h85);
    zp = {2'b00, 3'h7, 4'($random(seed)), 7'h00};
    fsp_cpu_model_inst.store(zp, 8'hff);
    #1;
    check(32'(cpu_halt_o), 32'h1);
    check(32'(lower_read_block_o), 32'h1);
    check(32'(flash_page_o), 32'(zp[13:7]));
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd & 32'h41, 32'h41);
    check(32'(irq_o), 32'h0);
    wait_op();
    apb(1'b0, CTRL_OFS, 32'h0);
    check(32'(rd[6]), 32'h1);
    check(32'(irq_o), 32'h1);
    apb(1'b1, CTRL_OFS, 32'h91);
    fsp_cpu_model_inst.store(16'h0000, 8'hff);
    apb(1'b0, CTRL_OFS, 32'h0);
    check(32'(rd[6]), 32'h0);
    // lower-section page write survives a system reset
    apb(1'b1, CTRL_OFS, 32'h05);
    fsp_cpu_model_inst.store({3'b000, 6'($random(seed)), 7'h00}, 8'hff);
    #1;
    check(32'(cpu_halt_o), 32'h0);
    check(32'(lower_read_block_o), 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check(32'(flash_write_o), 32'h1);
    wait_op();
    check(n, PROG - 2);
    final_report();
  end
endmodule // tb
